// ### dii_pkg.sv
// Constants shared by the debounced isolated input register block.
// Assumes a 100 MHz bus clock and a configuration core outside that forwards BAR cycles.
package dii_pkg;

  // ----------------------------------------------------------------------
  // Configuration space
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CFG_BAR_IO    = 8'h14;
  localparam logic [7:0]  CFG_BAR_MEM   = 8'h18;
  localparam int unsigned WIN_BITS      = 6;      // 64 byte window
  localparam int unsigned BAR_HI_W      = 32 - WIN_BITS;
  localparam logic [5:0]  BAR_IO_FLAGS  = 6'h01;  // Bit 0 marks I/O space
  localparam logic [5:0]  BAR_MEM_FLAGS = 6'h00;  // 32-bit, not prefetchable

  // ----------------------------------------------------------------------
  // User longword layout
  // ----------------------------------------------------------------------
  localparam int unsigned CHANNELS     = 16;
  localparam int unsigned LED_BIT      = 24;
  localparam int unsigned SEL_LSB      = 16;
  localparam int unsigned SEL_W        = 3;
  localparam int unsigned LANE_LED     = 3;
  localparam int unsigned LANE_SEL     = 2;
  localparam logic        LED_RST      = 1'b0;
  localparam logic [2:0]  SEL_RST      = 3'h0;
  localparam logic [6:0]  RSVD_HI_ZERO = 7'h00;   // Bits 31..25
  localparam logic [4:0]  RSVD_LO_ZERO = 5'h00;   // Bits 23..19

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 14;

  // Delay per select code, in microsecond ticks
  localparam logic [13:0] DLY_US_0 = 14'h0001; // 1.0 us
  localparam logic [13:0] DLY_US_1 = 14'h0080; // 128 us
  localparam logic [13:0] DLY_US_2 = 14'h0100; // 256 us
  localparam logic [13:0] DLY_US_3 = 14'h0200; // 512 us
  localparam logic [13:0] DLY_US_4 = 14'h0BFE; // 3.07 ms
  localparam logic [13:0] DLY_US_5 = 14'h17FC; // 6.14 ms
  localparam logic [13:0] DLY_US_6 = 14'h2404; // 9.22 ms
  localparam logic [13:0] DLY_US_7 = 14'h3002; // 12.29 ms

  function automatic logic [13:0] delay_ticks(input logic [2:0] code);
    logic [13:0] t;
    t = DLY_US_0;
    unique case (code)
      3'h0: t = DLY_US_0;
      3'h1: t = DLY_US_1;
      3'h2: t = DLY_US_2;
      3'h3: t = DLY_US_3;
      3'h4: t = DLY_US_4;
      3'h5: t = DLY_US_5;
      3'h6: t = DLY_US_6;
      3'h7: t = DLY_US_7;
    endcase
    return t;
  endfunction : delay_ticks

endpackage : dii_pkg

// ### dii_chan_if.sv
// Signals between the register top and one debounce channel.
// Assumes the top drives tick, select and the synchronised raw input; the channel drives level.
`timescale 1ns/1ns
interface dii_chan_if;
  logic       tick;
  logic [2:0] sel;
  logic       raw;
  logic       level;

  modport ctl  (output tick, output sel, output raw, input level);
  modport chan (input tick, input sel, input raw, output level);
endinterface : dii_chan_if

// ### dii_chan.sv
// One input channel: stability timer, then a hold stage of the same length.
// Assumes raw is already synchronised to clock and tick is a one-cycle 1 us pulse.
`timescale 1ns/1ns
module dii_chan (
  // Clock and reset
  input  logic         clock,
  input  logic         reset,
  // Link to the register top
  dii_chan_if.chan     bus
);

  logic             sample_q;
  logic [2:0]       code_q;
  logic [13:0]      cnt_q;
  logic [13:0]      cnt_d;
  logic             acc_q;
  logic             acc_d;
  logic [13:0]      dly_q;
  logic [13:0]      dly_d;
  logic             level_q;
  logic             level_d;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire        changed  = bus.raw != sample_q;
  wire [13:0] limit    = dii_pkg::delay_ticks(code_q);
  wire        cnt_done = !changed && (cnt_q == limit);
  wire        pending  = acc_q != level_q;
  // A glitch during the hold may shorten the limit; at-or-past keeps the hold from wrapping
  wire        dly_done = pending && (dly_q >= limit);

  // Any wiggle restarts the stability timer and picks up the select as it stands now
  assign cnt_d   = changed ? 14'h0000 : ((bus.tick && !cnt_done) ? cnt_q + 14'h0001 : cnt_q);
  assign acc_d   = cnt_done ? sample_q : acc_q;
  // Accepted level is held back one more interval before it shows
  assign dly_d   = (acc_d != acc_q || dly_done) ? 14'h0000 :
                   ((pending && bus.tick) ? dly_q + 14'h0001 : dly_q);
  assign level_d = dly_done ? acc_q : level_q;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sample_q <= 1'b0;
      code_q   <= dii_pkg::SEL_RST;
    end else begin
      sample_q <= bus.raw;
      code_q   <= changed ? bus.sel : code_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q   <= 14'h0000;
      acc_q   <= 1'b0;
      dly_q   <= 14'h0000;
      level_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      acc_q   <= acc_d;
      dly_q   <= dly_d;
      level_q <= level_d;
    end
  end

  assign bus.level = level_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_restart_on_change: assert property (@(posedge clock) disable iff (reset)
    changed |=> cnt_q == 14'h0000)
    else $error("stability timer not restarted on input change");

  a_level_from_accepted: assert property (@(posedge clock) disable iff (reset)
    $changed(level_q) |-> level_q == $past(acc_q) && $past(dly_q) >= $past(limit))
    else $error("level moved without a full hold interval");

  a_accept_needs_stable: assert property (@(posedge clock) disable iff (reset)
    $changed(acc_q) |-> $past(cnt_q) == $past(limit) && $past(sample_q) == $past(bus.raw))
    else $error("level accepted before the stability interval ended");

  c_level_rise: cover property (@(posedge clock) disable iff (reset) $rose(level_q));

endmodule : dii_chan

// ### dii_regs.sv
// Register logic of a 16 channel isolated input board behind a PCI target core.
// Assumes the outside core decodes bus cycles to one-cycle requests and forwards
// configuration cycles for the two base address registers.
//
// Notes on behaviour
// - A 64 byte window per space; all sixteen longwords alias the first.
// - I/O window set by config BAR 14h, memory window by BAR 18h.
// - The same user longword is seen through I/O and memory windows.
// - Control/status word sits in byte lanes 3 and 2.
// - Bits 31..25 and 23..19 read zero; writes to them are dropped.
// - Bit 24 read/write; one turns the fail indicator off, zero keeps it lit.
// - Reset clears bit 24 so the fail indicator is lit.
// - Bits 18..16 read/write debounce select, reset to 000.
// - Codes 0..7 pick 1 us, 128, 256, 512 us, 3.07, 6.14, 9.22, 12.29 ms.
// - Accepted input held one more interval; visible latency is twice the setting.
// - Low 16 bits are read-only; bit n is channel n.
// - Channel data is correct for byte, word and longword reads.
// - Inverted polarity: conducting optocoupler reads as zero.
// - Contact variant: open contact, high input, reads as zero.
// - No interrupt is ever requested; host polls.
`timescale 1ns/1ns
module dii_regs #(
  parameter int unsigned TICK_CYCLES = dii_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  logic        clock,
  input  logic        reset,
  // Configuration cycles for the base address registers
  input  logic        cfg_write,
  input  logic        cfg_read,
  input  logic [7:0]  cfg_addr,
  input  logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // Target requests in I/O or memory space
  input  logic        tgt_req,
  input  logic        tgt_write,
  input  logic        tgt_io,
  input  logic [31:0] tgt_addr,
  input  logic [3:0]  tgt_be_n,
  input  logic [31:0] tgt_wdata,
  output logic        tgt_hit,
  output logic        tgt_ack,
  output logic [31:0] tgt_rdata,
  // Field side
  input  logic [15:0] field_in,
  output logic        fail_led_n,
  output logic        int_req_n
);

  logic [15:0]                   in_meta_q;
  logic [15:0]                   in_sync_q;
  logic [6:0]                    pre_q;
  logic                          tick_q;
  logic [dii_pkg::BAR_HI_W-1:0]  bar_io_q;
  logic [dii_pkg::BAR_HI_W-1:0]  bar_mem_q;
  logic [31:0]                   cfg_rdata_q;
  logic [31:0]                   cfg_rdata_d;
  logic                          led_off_q;
  logic                          led_off_d;
  logic [2:0]                    sel_q;
  logic [2:0]                    sel_d;
  logic                          ack_q;
  logic [31:0]                   rdata_q;
  logic [15:0]                   level_vec;
  logic [31:0]                   image;

  dii_chan_if chan [dii_pkg::CHANNELS] ();

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  // Field pins are asynchronous; nothing looks at the first stage but the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      in_meta_q <= 16'h0000;
      in_sync_q <= 16'h0000;
    end else begin
      in_meta_q <= field_in;
      in_sync_q <= in_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Microsecond prescaler
  // ----------------------------------------------------------------------
  // One shared tick keeps each channel down to two 14-bit counters
  wire pre_wrap = pre_q == 7'(TICK_CYCLES - 1);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_wrap ? 7'h00 : pre_q + 7'h01;
      tick_q <= pre_wrap;
    end
  end

  // ----------------------------------------------------------------------
  // Base address registers
  // ----------------------------------------------------------------------
  wire cfg_io_sel  = cfg_addr == dii_pkg::CFG_BAR_IO;
  wire cfg_mem_sel = cfg_addr == dii_pkg::CFG_BAR_MEM;

  // Low six bits never store, so sizing software sees a 64 byte request
  assign cfg_rdata_d = cfg_io_sel  ? {bar_io_q, dii_pkg::BAR_IO_FLAGS} :
                       cfg_mem_sel ? {bar_mem_q, dii_pkg::BAR_MEM_FLAGS} : 32'h0000_0000;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bar_io_q  <= '0;
      bar_mem_q <= '0;
    end else begin
      if (cfg_write && cfg_io_sel)
        bar_io_q <= cfg_wdata[31:dii_pkg::WIN_BITS];
      if (cfg_write && cfg_mem_sel)
        bar_mem_q <= cfg_wdata[31:dii_pkg::WIN_BITS];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      cfg_rdata_q <= 32'h0000_0000;
    else if (cfg_read)
      cfg_rdata_q <= cfg_rdata_d;
  end

  assign cfg_rdata = cfg_rdata_q;

  // ----------------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------------
  // Offset bits 5..2 are ignored, so every longword aliases the first
  wire io_match  = tgt_addr[31:dii_pkg::WIN_BITS] == bar_io_q;
  wire mem_match = tgt_addr[31:dii_pkg::WIN_BITS] == bar_mem_q;
  wire hit       = tgt_req && (tgt_io ? io_match : mem_match);
  wire wr_hit    = hit && tgt_write;
  wire rd_hit    = hit && !tgt_write;

  assign tgt_hit = hit;

  // ----------------------------------------------------------------------
  // Control/status word
  // ----------------------------------------------------------------------
  // Only the implemented bits are stored; reserved positions have no flops
  assign led_off_d = (wr_hit && !tgt_be_n[dii_pkg::LANE_LED]) ? tgt_wdata[dii_pkg::LED_BIT] : led_off_q;
  assign sel_d     = (wr_hit && !tgt_be_n[dii_pkg::LANE_SEL]) ?
                     tgt_wdata[dii_pkg::SEL_LSB +: dii_pkg::SEL_W] : sel_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      led_off_q <= dii_pkg::LED_RST;
      sel_q     <= dii_pkg::SEL_RST;
    end else begin
      led_off_q <= led_off_d;
      sel_q     <= sel_d;
    end
  end

  // Low means lit, so a cleared bit keeps the indicator on
  assign fail_led_n = led_off_q;
  // The board never interrupts; the line is held inactive
  assign int_req_n  = 1'b1;

  // ----------------------------------------------------------------------
  // Debounce channels
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < dii_pkg::CHANNELS; i++) begin : g_chan
    assign chan[i].tick = tick_q;
    assign chan[i].sel  = sel_q;
    assign chan[i].raw  = in_sync_q[i];
    assign level_vec[i] = chan[i].level;

    dii_chan u_chan (
      .clock (clock),
      .reset (reset),
      .bus   (chan[i])
    );
  end

  // ----------------------------------------------------------------------
  // Read image
  // ----------------------------------------------------------------------
  // A high input reads back low on both sensing variants
  // All lanes are driven on every read; byte enables only gate writes
  assign image = {dii_pkg::RSVD_HI_ZERO, led_off_q, dii_pkg::RSVD_LO_ZERO, sel_q, ~level_vec};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= hit;
      rdata_q <= rd_hit ? image : rdata_q;
    end
  end

  assign tgt_ack   = ack_q;
  assign tgt_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_rsvd_read_zero: assert property (@(posedge clock) disable iff (reset)
    ack_q && $past(rd_hit) |-> tgt_rdata[31:25] == 7'h00 && tgt_rdata[23:19] == 5'h00)
    else $error("reserved bits read nonzero");

  a_read_alias: assert property (@(posedge clock) disable iff (reset)
    ack_q && $past(rd_hit) |-> tgt_rdata[24:16] == {$past(led_off_q), 5'h00, $past(sel_q)})
    else $error("aliased read differs from the control word");

  a_data_inverted: assert property (@(posedge clock) disable iff (reset)
    ack_q && $past(rd_hit) |-> tgt_rdata[15:0] == ~$past(level_vec))
    else $error("channel data not inverted");

  a_led_write: assert property (@(posedge clock) disable iff (reset)
    wr_hit && !tgt_be_n[3] |=> fail_led_n == $past(tgt_wdata[24]))
    else $error("fail indicator bit not written");

  a_led_lane_kept: assert property (@(posedge clock) disable iff (reset)
    !(wr_hit && !tgt_be_n[3]) |=> $stable(led_off_q))
    else $error("indicator bit changed without a lane 3 write");

  a_sel_write: assert property (@(posedge clock) disable iff (reset)
    wr_hit && !tgt_be_n[2] |=> sel_q == $past(tgt_wdata[18:16]))
    else $error("debounce select not written");

  a_reset_values: assert property (@(posedge clock) disable iff (reset)
    $past(reset) |-> !fail_led_n && sel_q == 3'h0)
    else $error("control word not cleared by reset");

  a_io_bar_flag: assert property (@(posedge clock) disable iff (reset)
    $past(cfg_read) && $past(cfg_io_sel) |-> cfg_rdata[5:0] == 6'h01)
    else $error("I/O base register flags wrong");

  // Cycles since the last tick; the first gap after reset is one longer
  logic [7:0] tick_gap_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      tick_gap_q <= 8'h00;
    else
      tick_gap_q <= tick_q ? 8'h00 : tick_gap_q + 8'h01;
  end

  a_tick_period: assert property (@(posedge clock) disable iff (reset)
    tick_q |-> tick_gap_q >= 8'(TICK_CYCLES - 1))
    else $error("prescaler ticks too close together");

  a_tick_late: assert property (@(posedge clock) disable iff (reset)
    tick_gap_q <= 8'(TICK_CYCLES))
    else $error("prescaler tick overdue");

  a_no_irq: assert property (@(posedge clock) disable iff (reset)
    int_req_n)
    else $error("interrupt requested");

  a_sel_lane_kept: assert property (@(posedge clock) disable iff (reset)
    !(wr_hit && !tgt_be_n[2]) |=> $stable(sel_q))
    else $error("debounce select changed without a lane 2 write");

  a_ack_follows_hit: assert property (@(posedge clock) disable iff (reset)
    hit |=> tgt_ack)
    else $error("hit not acknowledged");

  a_ack_needs_hit: assert property (@(posedge clock) disable iff (reset)
    !hit |=> !tgt_ack)
    else $error("acknowledge without a hit");

  a_miss_no_write: assert property (@(posedge clock) disable iff (reset)
    tgt_req && !hit |=> $stable(sel_q) && $stable(led_off_q))
    else $error("access outside the window changed the control word");

  a_rdata_kept: assert property (@(posedge clock) disable iff (reset)
    !rd_hit |=> $stable(tgt_rdata))
    else $error("read data moved without a read hit");

  a_mem_bar_flag: assert property (@(posedge clock) disable iff (reset)
    $past(cfg_read) && $past(cfg_mem_sel) |-> cfg_rdata[5:0] == 6'h00)
    else $error("memory base register flags wrong");

  a_cfg_other_zero: assert property (@(posedge clock) disable iff (reset)
    $past(cfg_read) && !$past(cfg_io_sel) && !$past(cfg_mem_sel) |-> cfg_rdata == 32'h0000_0000)
    else $error("undecoded configuration offset read nonzero");

  a_bar_io_write: assert property (@(posedge clock) disable iff (reset)
    cfg_write && cfg_io_sel |=> bar_io_q == $past(cfg_wdata[31:dii_pkg::WIN_BITS]))
    else $error("I/O base register not written");

  a_bar_mem_write: assert property (@(posedge clock) disable iff (reset)
    cfg_write && cfg_mem_sel |=> bar_mem_q == $past(cfg_wdata[31:dii_pkg::WIN_BITS]))
    else $error("memory base register not written");

  a_cfg_rdata_kept: assert property (@(posedge clock) disable iff (reset)
    !cfg_read |=> $stable(cfg_rdata))
    else $error("configuration read data moved without a read");

  c_io_read:   cover property (@(posedge clock) disable iff (reset) rd_hit && tgt_io);
  c_mem_write: cover property (@(posedge clock) disable iff (reset) wr_hit && !tgt_io && !tgt_be_n[2]);
  c_alias_hi:  cover property (@(posedge clock) disable iff (reset) rd_hit && tgt_addr[5:2] == 4'hF);
  c_led_off:   cover property (@(posedge clock) disable iff (reset) $rose(fail_led_n));

endmodule : dii_regs

// ### dii_host.sv
// Host controller model: issues configuration and target cycles to the register block.
// Assumes one calling thread and the bus clock; requests are one-cycle pulses.
`timescale 1ns/1ns
module dii_host (
  // Clock
  input  logic        clock,
  // Configuration cycles
  output logic        cfg_write,
  output logic        cfg_read,
  output logic [7:0]  cfg_addr,
  output logic [31:0] cfg_wdata,
  input  logic [31:0] cfg_rdata,
  // Target cycles
  output logic        tgt_req,
  output logic        tgt_write,
  output logic        tgt_io,
  output logic [31:0] tgt_addr,
  output logic [3:0]  tgt_be_n,
  output logic [31:0] tgt_wdata,
  input  logic        tgt_hit,
  input  logic        tgt_ack,
  input  logic [31:0] tgt_rdata
);
  initial begin
    {cfg_write, cfg_read, tgt_req, tgt_write, tgt_io} = 5'h00;
    cfg_addr  = 8'h00;
    cfg_wdata = 32'h00000000;
    tgt_addr  = 32'h00000000;
    tgt_be_n  = 4'hF;
    tgt_wdata = 32'h00000000;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic cfg_access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                            output logic [31:0] rd);
    @(posedge clock);
    cfg_write <= wr;
    cfg_read  <= ~wr;
    cfg_addr  <= addr;
    cfg_wdata <= data;
    @(posedge clock);
    cfg_write <= 1'b0;
    cfg_read  <= 1'b0;
    // Released data flips so a stale value never looks valid
    cfg_wdata <= ~data;
    #1;
    rd = cfg_rdata;
  endtask : cfg_access

  task automatic tgt_access(input logic wr, input logic io, input logic [31:0] addr, input logic [3:0] be_n,
                            input logic [31:0] data, input logic keep, output logic [31:0] rd,
                            output logic hit, output logic ack);
    @(posedge clock);
    tgt_req   <= 1'b1;
    tgt_write <= wr;
    tgt_io    <= io;
    tgt_addr  <= addr;
    tgt_be_n  <= be_n;
    tgt_wdata <= keep ? data : (data & 32'h0107FFFF);
    #1;
    hit = tgt_hit;
    @(posedge clock);
    tgt_req   <= 1'b0;
    tgt_addr  <= ~addr;
    tgt_wdata <= ~data;
    #1;
    ack = tgt_ack;
    rd  = tgt_rdata;
  endtask : tgt_access
endmodule : dii_host

// ### tb_debounced_isolated_input_regs.sv
// Self-checking bench for the isolated input register block.
// Assumes a shortened prescaler so that debounce delays stay within the run.
`timescale 1ns/1ns
module tb_debounced_isolated_input_regs;
  localparam int unsigned TICKS = 4;
  localparam int          LIMIT = 50000;

  logic        clock, reset;
  logic        cfg_write, cfg_read, tgt_req, tgt_write, tgt_io;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, tgt_addr, tgt_wdata, tgt_rdata;
  logic [3:0]  tgt_be_n;
  logic        tgt_hit, tgt_ack, fail_led_n, int_req_n;
  logic [15:0] field_in, exp_lvl, nxt;
  logic [31:0] rd, io_base, mem_base;
  logic        hit, ack, exp_led;
  logic [2:0]  exp_sel;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          seed = 69;
  int          dly_us [8] = '{1, 128, 256, 512, 3070, 6140, 9220, 12290};

  dii_regs #(.TICK_CYCLES(TICKS)) dut (
    .clock(clock), .reset(reset), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .tgt_req(tgt_req), .tgt_write(tgt_write),
    .tgt_io(tgt_io), .tgt_addr(tgt_addr), .tgt_be_n(tgt_be_n), .tgt_wdata(tgt_wdata), .tgt_hit(tgt_hit),
    .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata), .field_in(field_in), .fail_led_n(fail_led_n),
    .int_req_n(int_req_n));

  dii_host host (
    .clock(clock), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .tgt_req(tgt_req), .tgt_write(tgt_write), .tgt_io(tgt_io), .tgt_addr(tgt_addr),
    .tgt_be_n(tgt_be_n), .tgt_wdata(tgt_wdata), .tgt_hit(tgt_hit), .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Accesses at a random alias inside the chosen window
  // ----------------------------------------------------------------------
  task automatic wr_csr(input logic io, input logic [3:0] be_n, input logic [31:0] data, input logic keep);
    host.tgt_access(1'b1, io, (io ? io_base : mem_base) | (32'($random(seed)) & 32'h3F), be_n, data,
                    keep, rd, hit, ack);
    if (!be_n[3])
      exp_led = data[24];
    if (!be_n[2])
      exp_sel = data[18:16];
    chk_bit(hit, 1'b1);
    chk_bit(ack, 1'b1);
    chk_bit(fail_led_n, exp_led);
  endtask : wr_csr

  task automatic rd_chk(input logic io, input logic [3:0] be_n);
    host.tgt_access(1'b0, io, (io ? io_base : mem_base) | (32'($random(seed)) & 32'h3F), be_n,
                    32'h00000000, 1'b0, rd, hit, ack);
    chk_bit(ack, 1'b1);
    chk_word(rd, {7'h00, exp_led, 5'h00, exp_sel, ~exp_lvl});
  endtask : rd_chk

  initial begin
    reset    = 1'b1;
    field_in = 16'h0000;
    exp_lvl  = 16'h0000;
    exp_led  = 1'b0;
    exp_sel  = 3'h0;
    io_base  = 32'h00000000;
    mem_base = 32'h00000000;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd_chk(1'b0, 4'h0);
    chk_bit(fail_led_n, 1'b0);
    io_base  = 32'($random(seed)) & 32'hFFFFFFC0;
    mem_base = 32'($random(seed)) & 32'hFFFFFFC0;
    host.cfg_access(1'b1, 8'h14, io_base | 32'h3F, rd);
    host.cfg_access(1'b1, 8'h18, mem_base | 32'h2A, rd);
    host.cfg_access(1'b0, 8'h14, 32'h00000000, rd);
    chk_word(rd, io_base | 32'h01);
    host.cfg_access(1'b0, 8'h18, 32'h00000000, rd);
    chk_word(rd, mem_base);
    host.cfg_access(1'b0, 8'h10, 32'h00000000, rd);
    chk_word(rd, 32'h00000000);
    // Reserved ones must vanish; only lanes 3 and 2 enabled
    wr_csr(1'b1, 4'b0011, 32'hFFFFFFFF, 1'b1);
    rd_chk(1'b0, 4'b1110);
    rd_chk(1'b0, 4'b1100);
    rd_chk(1'b1, 4'h0);
    wr_csr(1'b0, 4'b0111, 32'h00000000, 1'b0);
    rd_chk(1'b1, 4'h0);
    host.tgt_access(1'b1, 1'b1, io_base + 32'h40, 4'h0, 32'hFFFFFFFF, 1'b1, rd, hit, ack);
    chk_bit(hit, 1'b0);
    chk_bit(ack, 1'b0);
    rd_chk(1'b0, 4'h0);
    for (int k = 0; k < 8; k++) begin
      wr_csr(k[0], 4'h0, {7'h00, k[0], 5'h00, 3'(k), 16'hFFFF}, 1'b0);
      rd_chk(~k[0], 4'h0);
      if (k < 5) begin
        nxt = 16'($random(seed));
        @(posedge clock);
        field_in <= nxt;
        repeat (dly_us[k] * TICKS) @(posedge clock);
        if (k > 0)
          rd_chk(1'b0, 4'h0);
        repeat (dly_us[k] * TICKS + 2 * TICKS + 10) @(posedge clock);
        exp_lvl = nxt;
        rd_chk(1'b1, 4'h0);
      end
    end
    // A pulse shorter than the 128 us interval is never accepted
    wr_csr(1'b0, 4'h0, 32'h00010000, 1'b0);
    @(posedge clock);
    field_in <= ~exp_lvl;
    repeat (200) @(posedge clock);
    field_in <= exp_lvl;
    repeat (1200) @(posedge clock);
    rd_chk(1'b0, 4'h0);
    chk_bit(int_req_n, 1'b1);
    give_verdict();
  end
endmodule : tb_debounced_isolated_input_regs
